// file: hdl/mag_pkg.sv
package mag_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Typical conversion time of one three-axis measurement.
  localparam int unsigned MEAS_TIME_NS = 792_000;
  localparam int unsigned MEAS_CYCLES_DEF = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_HZ_DEF = 6_250_000;
  localparam int unsigned MILLIHZ_PER_HZ = 1000;
  localparam int unsigned RATE_MILLIHZ [1:7] = '{250, 500, 1000, 10000, 20000, 50000, 100000};

  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_STATUS = 7'h10;
  localparam logic [6:0] ADDR_DATA_LO = 7'h11;
  localparam logic [6:0] ADDR_DATA_HI = 7'h16;
  localparam logic [6:0] ADDR_SET_LO = 7'h20;
  localparam logic [6:0] ADDR_EVENT_CTRL = 7'h20;
  localparam logic [6:0] ADDR_MEAS_CTRL = 7'h21;
  localparam logic [6:0] ADDR_SET_HI = 7'h27;
  localparam logic [6:0] ADDR_THR_LO = 7'h30;
  localparam logic [6:0] ADDR_THR_HI = 7'h47;

  localparam int EVT_DATA_READY_FLAG_EN_BIT = 0;
  localparam int EVT_PP_EN_BIT = 1;
  localparam int EVT_OD_EN_BIT = 2;
  localparam int EVT_SOFT_RST_BIT = 7;
  localparam int SET_EVENT_IDX = 0;
  localparam int SET_MEAS_IDX = 1;
  localparam int SET_BYTES = 8;

  localparam int NUM_CH = 6;
  localparam int THR_BYTES = 24;
  localparam int THR_OP_OFS = 0;
  localparam int THR_REL_OFS = 2;
  localparam int THR_CH_BYTES = 4;
  localparam int AXIS_CH = 2;

  typedef enum logic [3:0] {
    MODE_POWER_DOWN = 4'h0,
    MODE_SINGLE = 4'h1,
    MODE_CONT1 = 4'h2,
    MODE_CONT2 = 4'h4,
    MODE_CONT3 = 4'h6,
    MODE_CONT4 = 4'h8,
    MODE_CONT5 = 4'hA,
    MODE_CONT6 = 4'hC,
    MODE_CONT7 = 4'hE
  } mode_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_MEAS = 2'b01,
    SEQ_SAVE = 2'b10
  } seq_e;

endpackage

// file: hdl/mag_measure_sequencer.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps

// Function
// - Pin or soft reset clears registers, powers down.
// - Mode 0000 power-down, 0001 single measurement.
// - Even modes 0010 to 1110 are continuous 1-7.
// - Continuous rates 0.25 to 100 Hz.
// - Defined mode write starts that mode.
// - Power-down keeps registers accessible and retained.
// - Single result stored, mode cleared, ready set.
// - Between measurements only period counter runs.
// - Setting access in continuous mode stops updates.
// - Rewriting measure control restarts measurement.
// - New mode or threshold write ends continuous.
// - Stored result sets data ready flag.
// - Ready enable routes ready to event pins.
// - Status plus data read clears ready, overrun.
// - Data access freezes results until read ends.
// - Data keep previous result during measurement.
// - Unread result: skip one set, flag overrun.
// - Read in progress: defer result, no overrun.
// - Threshold compare sets, clears or holds state.
// - Channel active only when operate above release.
// - Six channels, two per axis.
// - Event drives push-pull high, open-drain low.
module mag_measure_sequencer #(
  parameter int unsigned MEAS_CYCLES = mag_pkg::MEAS_CYCLES_DEF,
  parameter int unsigned OSC_HZ = mag_pkg::OSC_HZ_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hard_reset_pin_n,
  input wire logic osc_clk_pin,
  input wire logic [mag_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [15:0] x_adc,
  input wire logic [15:0] y_adc,
  input wire logic [15:0] z_adc,
  output logic sensor_power_on,
  output logic push_pull_event_pin,
  output logic open_drain_event_pin_o,
  output logic open_drain_event_pin_oe_n
);
  import mag_pkg::*;

  typedef struct packed {
    seq_e state;
    logic [SET_BYTES-1:0][7:0] set;
    logic [THR_BYTES-1:0][7:0] thr;
    logic [15:0] x_data;
    logic [15:0] y_data;
    logic [15:0] z_data;
    logic [15:0] x_pend;
    logic [15:0] y_pend;
    logic [15:0] z_pend;
    logic pending;
    logic data_ready_flag;
    logic data_overrun_flag;
    logic [NUM_CH-1:0] sw;
    logic stopped;
    logic reading;
    logic st_read;
    logic [31:0] meas_cnt;
    logic [31:0] per_cnt;
    logic rst_s1;
    logic rst_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic [7:0] rdata;
    logic power;
    logic int_pin;
    logic od_oe_n;
    logic od_o;
  } state_s;

  localparam state_s RESET_S = '{state: SEQ_IDLE, od_oe_n: 1'b1, rst_s1: 1'b1, rst_s2: 1'b1, default: '0};

  state_s r;
  state_s n;
  logic tick;
  logic meas_done;
  logic set_acc;
  logic thr_stop;
  logic finish;
  logic do_store;
  logic soft_rst;
  logic [15:0] sx;
  logic [15:0] sy;
  logic [15:0] sz;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic in_range(logic [6:0] a, logic [6:0] lo, logic [6:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic mode_defined(logic [3:0] m);
    return (m == MODE_POWER_DOWN) || (m == MODE_SINGLE) || (m[0] == 1'b0);
  endfunction

  function automatic logic mode_cont(logic [3:0] m);
    return (m != MODE_POWER_DOWN) && (m[0] == 1'b0);
  endfunction

  function automatic logic [31:0] period_ticks(logic [3:0] m);
    logic [63:0] t;
    t = '1;
    if (m[3:1] != 3'h0) begin
      t = (64'(OSC_HZ) * 64'(MILLIHZ_PER_HZ)) / 64'(RATE_MILLIHZ[int'(m[3:1])]);
    end
    return t[31:0];
  endfunction

  function automatic logic sw_eval(logic [15:0] d, logic [15:0] op, logic [15:0] rel, logic old);
    logic res;
    res = old;
    if ($signed(op) > $signed(rel)) begin
      if ($signed(d) > $signed(op)) begin
        res = 1'b1;
      end else if ($signed(d) < $signed(rel)) begin
        res = 1'b0;
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] reg_value(state_s s, logic [6:0] a);
    logic [47:0] d;
    logic [7:0] v;
    d = {s.x_data, s.y_data, s.z_data};
    v = '0;
    if (a == ADDR_STATUS) begin
      v = {s.sw, s.data_overrun_flag, s.data_ready_flag};
    end else if (in_range(a, ADDR_DATA_LO, ADDR_DATA_HI)) begin
      v = d[8'(47 - 8 * int'(a - ADDR_DATA_LO)) -: 8];
    end else if (in_range(a, ADDR_SET_LO, ADDR_SET_HI)) begin
      v = s.set[3'(a - ADDR_SET_LO)];
    end else if (in_range(a, ADDR_THR_LO, ADDR_THR_HI)) begin
      v = s.thr[5'(a - ADDR_THR_LO)];
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Oscillator edges are found after the two-flop synchroniser.
  assign tick = r.osc_s2 & ~r.osc_prev;
  assign meas_done = (r.state == SEQ_MEAS) && (r.meas_cnt == 32'(MEAS_CYCLES - 1));

  always_comb begin
    n = r;
    finish = 1'b0;
    do_store = 1'b0;
    soft_rst = 1'b0;
    sx = x_adc;
    sy = y_adc;
    sz = z_adc;
    n.rst_s1 = hard_reset_pin_n;
    n.rst_s2 = r.rst_s1;
    n.osc_s1 = osc_clk_pin;
    n.osc_s2 = r.osc_s1;
    n.osc_prev = r.osc_s2;
    n.rdata = '0;
    set_acc = (rd || wr) && in_range(addr, ADDR_SET_LO, ADDR_SET_HI);
    thr_stop = wr && in_range(addr, ADDR_THR_LO, ADDR_THR_HI) && mode_cont(r.set[SET_MEAS_IDX][3:0]);
    // Register reads; every register stays reachable in any mode.
    if (rd) begin
      n.rdata = reg_value(r, addr);
      if (addr == ADDR_STATUS) begin
        n.st_read = 1'b1;
      end
    end
    if ((rd || wr) && in_range(addr, ADDR_DATA_LO, ADDR_DATA_HI)) begin
      n.reading = 1'b1;
    end
    if (rd && (addr == ADDR_DATA_HI)) begin
      finish = 1'b1;
      n.reading = 1'b0;
      n.st_read = 1'b0;
      if (r.st_read) begin
        n.data_ready_flag = 1'b0;
        n.data_overrun_flag = 1'b0;
      end
      if (r.pending) begin
        do_store = 1'b1;
        n.pending = 1'b0;
        sx = r.x_pend;
        sy = r.y_pend;
        sz = r.z_pend;
      end
    end
    if (set_acc) begin
      n.data_ready_flag = 1'b0;
      n.data_overrun_flag = 1'b0;
      n.st_read = 1'b0;
      if (mode_cont(r.set[SET_MEAS_IDX][3:0])) begin
        n.stopped = 1'b1;
        n.state = SEQ_IDLE;
      end
    end
    if (wr && in_range(addr, ADDR_SET_LO, ADDR_SET_HI)) begin
      if (addr == ADDR_MEAS_CTRL) begin
        if (mode_defined(wdata[3:0])) begin
          n.set[SET_MEAS_IDX] = wdata;
          n.stopped = 1'b0;
          n.meas_cnt = '0;
          n.per_cnt = '0;
          n.state = (wdata[3:0] == MODE_POWER_DOWN) ? SEQ_IDLE : SEQ_MEAS;
        end
      end else if ((addr == ADDR_EVENT_CTRL) && wdata[EVT_SOFT_RST_BIT]) begin
        soft_rst = 1'b1;
      end else begin
        n.set[3'(addr - ADDR_SET_LO)] = wdata;
      end
    end
    if (wr && in_range(addr, ADDR_THR_LO, ADDR_THR_HI)) begin
      n.thr[5'(addr - ADDR_THR_LO)] = wdata;
    end
    if (thr_stop) begin
      n.set[SET_MEAS_IDX][3:0] = MODE_POWER_DOWN;
      n.state = SEQ_IDLE;
    end
    // Sequencer runs only when no setting access or continuous-mode threshold write redirected it this cycle.
    if (!set_acc && !thr_stop) begin
      unique case (r.state)
        SEQ_IDLE: begin
        end
        SEQ_MEAS: begin
          n.meas_cnt = r.meas_cnt + 32'h1;
          if (meas_done) begin
            if (r.set[SET_MEAS_IDX][3:0] == MODE_SINGLE) begin
              n.set[SET_MEAS_IDX][3:0] = MODE_POWER_DOWN;
              n.state = SEQ_IDLE;
            end else begin
              n.state = SEQ_SAVE;
            end
            if (n.reading) begin
              n.pending = 1'b1;
              n.x_pend = x_adc;
              n.y_pend = y_adc;
              n.z_pend = z_adc;
            end else if (n.data_ready_flag && !n.data_overrun_flag) begin
              n.data_overrun_flag = 1'b1;
            end else begin
              do_store = 1'b1;
              n.data_overrun_flag = 1'b0;
            end
          end
        end
        SEQ_SAVE: begin
        end
        default: begin
          n.state = SEQ_IDLE;
        end
      endcase
      if ((r.state != SEQ_IDLE) && mode_cont(r.set[SET_MEAS_IDX][3:0]) && tick) begin
        if (r.per_cnt >= period_ticks(r.set[SET_MEAS_IDX][3:0]) - 32'h1) begin
          n.per_cnt = '0;
          n.state = SEQ_MEAS;
          n.meas_cnt = '0;
        end else begin
          n.per_cnt = r.per_cnt + 32'h1;
        end
      end
    end
    // Results only change here, so data hold the last set while measuring.
    if (do_store) begin
      n.x_data = sx;
      n.y_data = sy;
      n.z_data = sz;
      n.data_ready_flag = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        n.sw[c] = sw_eval((c / AXIS_CH == 0) ? sx : ((c / AXIS_CH == 1) ? sy : sz),
          {r.thr[c * THR_CH_BYTES + THR_OP_OFS], r.thr[c * THR_CH_BYTES + THR_OP_OFS + 1]},
          {r.thr[c * THR_CH_BYTES + THR_REL_OFS], r.thr[c * THR_CH_BYTES + THR_REL_OFS + 1]},
          r.sw[c]);
      end
    end
    n.power = (n.state == SEQ_MEAS);
    n.int_pin = n.data_ready_flag & n.set[SET_EVENT_IDX][EVT_DATA_READY_FLAG_EN_BIT] & n.set[SET_EVENT_IDX][EVT_PP_EN_BIT];
    n.od_oe_n = ~(n.data_ready_flag & n.set[SET_EVENT_IDX][EVT_DATA_READY_FLAG_EN_BIT] & n.set[SET_EVENT_IDX][EVT_OD_EN_BIT]);
    n.od_o = 1'b0;
    if (!r.rst_s2 || soft_rst) begin
      n = RESET_S;
      n.rst_s1 = hard_reset_pin_n;
      n.rst_s2 = r.rst_s1;
      n.osc_s1 = osc_clk_pin;
      n.osc_s2 = r.osc_s1;
      n.osc_prev = r.osc_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= RESET_S;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign sensor_power_on = r.power;
  assign push_pull_event_pin = r.int_pin;
  assign open_drain_event_pin_o = r.od_o;
  assign open_drain_event_pin_oe_n = r.od_oe_n;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !r.rst_s2);

  a_reset_power_down: assert property ($rose(r.rst_s2) |->
    (r.state == SEQ_IDLE) && (r.set[SET_MEAS_IDX][3:0] == MODE_POWER_DOWN) && !r.data_ready_flag)
    else $error("reset did not leave power-down state");

  a_single_return: assert property ((meas_done && !set_acc && !thr_stop && !soft_rst &&
    (r.set[SET_MEAS_IDX][3:0] == MODE_SINGLE)) |=>
    (r.state == SEQ_IDLE) && (r.set[SET_MEAS_IDX][3:0] == MODE_POWER_DOWN))
    else $error("single measurement did not return to power-down");

  a_store_ready: assert property ((do_store && !soft_rst) |=> r.data_ready_flag)
    else $error("stored result without data ready");

  a_push_pull_pin: assert property (push_pull_event_pin ==
    (r.data_ready_flag && r.set[SET_EVENT_IDX][EVT_DATA_READY_FLAG_EN_BIT] && r.set[SET_EVENT_IDX][EVT_PP_EN_BIT]))
    else $error("push-pull pin disagrees with data ready");

  a_open_drain_pin: assert property (!open_drain_event_pin_oe_n ==
    (r.data_ready_flag && r.set[SET_EVENT_IDX][EVT_DATA_READY_FLAG_EN_BIT] && r.set[SET_EVENT_IDX][EVT_OD_EN_BIT]))
    else $error("open-drain pin disagrees with data ready");

  a_setting_clear: assert property ((set_acc && !do_store) |=> !r.data_ready_flag && !r.data_overrun_flag)
    else $error("setting access did not clear flags");

  a_read_freeze: assert property ((r.reading && !finish && !soft_rst) |=>
    $stable(r.x_data) && $stable(r.y_data) && $stable(r.z_data))
    else $error("data changed during a read");

  a_overrun_set: assert property ((meas_done && r.data_ready_flag && !r.data_overrun_flag && !r.reading && !rd && !wr &&
    (r.state == SEQ_MEAS)) |=> r.data_overrun_flag && r.data_ready_flag && $stable(r.x_data))
    else $error("skipped result did not flag overrun");

  a_overrun_ready: assert property (r.data_overrun_flag |-> r.data_ready_flag)
    else $error("overrun without data ready");

  a_defer_result: assert property ((meas_done && r.reading && !rd && !wr) |=>
    r.pending && $stable(r.x_data) && $stable(r.data_overrun_flag))
    else $error("result during read not deferred");

  a_period_wake: assert property ((r.state == SEQ_SAVE && tick && !rd && !wr &&
    r.per_cnt >= period_ticks(r.set[SET_MEAS_IDX][3:0]) - 32'h1) |=> r.state == SEQ_MEAS)
    else $error("period end did not wake measurement");

  c_single_done: cover property (meas_done && r.set[SET_MEAS_IDX][3:0] == MODE_SINGLE);
  c_overrun: cover property ($rose(r.data_overrun_flag));
  c_deferred_store: cover property (finish && r.pending);
  c_wake: cover property (r.state == SEQ_SAVE ##1 r.state == SEQ_MEAS);

endmodule

// file: tb/sensor_front_model.sv
`timescale 1ns/100ps
module sensor_front_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sensor_power_on,
  output logic osc_clk_pin,
  output logic [15:0] x_adc,
  output logic [15:0] y_adc,
  output logic [15:0] z_adc
);
  logic [7:0] n_r;
  logic pwr_r;
  ////////////////////////////////////////////////////////////
  // The periodic oscillator runs free, out of phase with clk.
  initial begin
    osc_clk_pin = 1'b0;
    #37;
    forever #80 osc_clk_pin = ~osc_clk_pin;
  end
  ////////////////////////////////////////////////////////////
  // Each finished measurement moves the converter to a new value set.
  always_ff @(posedge clk) begin
    if (rst) begin
      n_r <= 8'h00;
      pwr_r <= 1'b0;
    end else begin
      pwr_r <= sensor_power_on;
      if (pwr_r && !sensor_power_on) begin
        n_r <= n_r + 8'h01;
      end
    end
  end
  assign x_adc = {8'h10, n_r};
  assign y_adc = {8'h20, n_r};
  assign z_adc = {8'h30, n_r};
endmodule

// file: tb/mag_measure_sequencer_tb_top.sv
`timescale 1ns/100ps
module mag_measure_sequencer_tb_top;
  import mag_pkg::*;
  logic clk, rst, hard_reset_pin_n, wr, rd, osc_clk_pin, sensor_power_on;
  logic push_pull_event_pin, open_drain_event_pin_o, open_drain_event_pin_oe_n;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] x_adc, y_adc, z_adc;
  logic [7:0] pins;
  logic [7:0] thr [8] = '{8'h08, 8'h00, 8'h04, 8'h00, 8'h20, 8'h00, 8'h18, 8'h00};
  logic [7:0] modes [7] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E};
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  mag_measure_sequencer #(.MEAS_CYCLES(20), .OSC_HZ(100)) mag_measure_sequencer_inst (
    .clk(clk), .rst(rst), .hard_reset_pin_n(hard_reset_pin_n), .osc_clk_pin(osc_clk_pin),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .x_adc(x_adc), .y_adc(y_adc), .z_adc(z_adc), .sensor_power_on(sensor_power_on),
    .push_pull_event_pin(push_pull_event_pin), .open_drain_event_pin_o(open_drain_event_pin_o),
    .open_drain_event_pin_oe_n(open_drain_event_pin_oe_n));
  sensor_front_model sensor_front_model_inst (
    .clk(clk), .rst(rst), .sensor_power_on(sensor_power_on), .osc_clk_pin(osc_clk_pin),
    .x_adc(x_adc), .y_adc(y_adc), .z_adc(z_adc));
  assign pins = {5'h00, open_drain_event_pin_o, push_pull_event_pin, open_drain_event_pin_oe_n};
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & mask, exp);
  endtask
  task automatic rd_data(input logic [7:0] n);
    logic [7:0] e [6];
    e = '{8'h10, n, 8'h20, n, 8'h30, n};
    for (int i = 0; i < 6; i++) begin
      rd_chk(ADDR_DATA_LO + 7'(i), 8'hFF, e[i]);
    end
  endtask
  // Counts cycles in which the sensor is powered; none are expected.
  task automatic quiet(input int n);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (sensor_power_on !== 1'b0) hi++;
    end
    chk(hi[7:0], 8'h00);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    hard_reset_pin_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_STATUS, 8'hFF, 8'h00);
    rd_chk(ADDR_MEAS_CTRL, 8'hFF, 8'h00);
    foreach (thr[i]) wr_reg(ADDR_THR_LO + 7'(i), thr[i]);
    wr_reg(ADDR_EVENT_CTRL, 8'h07);
    wr_reg(ADDR_MEAS_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, sensor_power_on}, 8'h01);
    repeat (30) @(posedge clk);
    #1;
    chk(pins, 8'h02);
    // Status goes first: any access to the setting block would drop the ready flag.
    rd_chk(ADDR_STATUS, 8'hFF, 8'h05);
    rd_data(8'h00);
    chk(pins, 8'h01);
    rd_chk(ADDR_STATUS, 8'hFF, 8'h04);
    rd_chk(ADDR_MEAS_CTRL, 8'hFF, 8'h00);
    // Continuous mode at 10 Hz: one period is 80 clock cycles here.
    wr_reg(ADDR_MEAS_CTRL, 8'h08);
    repeat (50) @(posedge clk);
    rd_chk(ADDR_STATUS, 8'h03, 8'h01);
    repeat (80) @(posedge clk);
    rd_chk(ADDR_STATUS, 8'h03, 8'h03);
    rd_data(8'h01);
    rd_chk(ADDR_STATUS, 8'h03, 8'h00);
    wr_reg(ADDR_SET_LO + 7'h02, 8'h5A);
    quiet(200);
    rd_chk(ADDR_STATUS, 8'h01, 8'h00);
    wr_reg(ADDR_MEAS_CTRL, 8'h08);
    repeat (40) @(posedge clk);
    #1;
    chk({7'h00, sensor_power_on}, 8'h00);
    rd_chk(ADDR_STATUS, 8'h01, 8'h01);
    // A read begun before the next result lands holds that result back until the read completes.
    rd_chk(ADDR_DATA_LO, 8'hFF, 8'h10);
    repeat (70) @(posedge clk);
    rd_chk(ADDR_STATUS, 8'h03, 8'h01);
    rd_data(8'h03);
    rd_data(8'h04);
    rd_chk(ADDR_STATUS, 8'h03, 8'h01);
    wr_reg(ADDR_THR_LO, 8'h08);
    quiet(200);
    wr_reg(ADDR_MEAS_CTRL, 8'h08);
    repeat (30) @(posedge clk);
    wr_reg(ADDR_MEAS_CTRL, 8'h00);
    quiet(200);
    rd_chk(ADDR_SET_LO + 7'h02, 8'hFF, 8'h5A);
    wr_reg(ADDR_EVENT_CTRL, 8'h80);
    rd_chk(ADDR_SET_LO + 7'h02, 8'hFF, 8'h00);
    rd_chk(ADDR_EVENT_CTRL, 8'hFF, 8'h00);
    foreach (modes[i]) begin
      wr_reg(ADDR_MEAS_CTRL, modes[i]);
      rd_chk(ADDR_MEAS_CTRL, 8'h0F, modes[i]);
      wr_reg(ADDR_MEAS_CTRL, 8'h00);
    end
    wr_reg(ADDR_MEAS_CTRL, 8'h03);
    rd_chk(ADDR_MEAS_CTRL, 8'hFF, 8'h00);
    rd_chk(7'h7F, 8'hFF, 8'h00);
    wr_reg(ADDR_SET_LO + 7'h03, 8'hA5);
    @(posedge clk);
    hard_reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    hard_reset_pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_SET_LO + 7'h03, 8'hFF, 8'h00);
    give_verdict();
  end
endmodule
